// ### hdl/genlock_serial_port.sv
// Operation
// - While locked, pulse line sync low at each wrap of the line period counter.
// - Line sync falls keep a fixed cycle spacing except after a head switch.
// - While locked, field sync falls after first vertical sync of blanking.
// - Composite bus carries one eight-bit sample every two clocks.
// - During horizontal sync the bus carries field, frequency and phase words.
// - Control and status move one bit at a time over the serial line.
// - Port select and read-not-write low: each chip select strobe shifts one data bit in.
// - Port select high: chip select fall copies shift register into control.
// - Chip select high: serial line is released and its value ignored.
// - Read-not-write low and port select low: host writes data.
// - Read-not-write high and port select low: device drives status bits.
// - Reset low: state machines idle, control defaults, outputs disabled.
// - After reset release, operation resumes with default configuration.
// - Interrupt goes low after 128 or more unlocked lines in a field.
// - Interrupt returns high once horizontal lock is established.
// - Window flag high when sync lands within sixteen pixels of prediction.
// - Window flag low when sync misses the predicted window.
// - Configuration lives in one forty-seven-bit control register.
// - A twelve-bit read-only status word is read through the port.
`timescale 1ns/100ps
module genlock_serial_port #(
    parameter logic [genlock_pkg::LINE_CNT_W-1:0] LINE_PERIOD = genlock_pkg::LINE_PERIOD_DEFAULT
) (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst_b,
    // Serial host port
    input  wire genlock_pkg::serial_in_t           hostIn,
    output logic                                   serial_data_line_out,
    output logic                                   serial_data_line_oe_b,
    output logic [genlock_pkg::CTRL_W-1:0]         controlOut,
    input  wire logic [genlock_pkg::STATUS_W-1:0]  statusIn,
    // Incoming video timing and lock
    input  wire logic                              hsyncIn_b,
    input  wire logic                              vsyncIn_b,
    input  wire logic                              vblankIn,
    input  wire logic                              hLockIn,
    input  wire logic                              headSwitchIn,
    // Sync and flag outputs
    output logic                                   genlocked_line_sync_out_b,
    output logic                                   genlocked_field_sync_out_b,
    output logic                                   lockLossInt_b,
    output logic                                   syncWindowHit,
    output logic                                   busOe_b,
    // Composite stream
    input  wire logic [genlock_pkg::COMP_W-1:0]    videoIn,
    input  wire genlock_pkg::anc_t                 ancIn,
    output logic [genlock_pkg::COMP_W-1:0]         composite_output_bus,
    output logic                                   compValid,
    input  wire logic                              compReady,
    output logic                                   sampleLost
);
    import genlock_pkg::*;

    // ------------------------------------------------------------------
    // Serial host port
    // ------------------------------------------------------------------
    port_state_t         state_reg;
    port_state_t         state_next;
    logic [CTRL_W-1:0]   shift_reg;
    logic [CTRL_W-1:0]   shift_next;
    logic [CTRL_W-1:0]   control_reg;
    logic [CTRL_W-1:0]   control_next;
    logic [STATUS_W-1:0] statusShift_reg;
    logic [STATUS_W-1:0] statusShift_next;
    logic                csPrev_reg;
    logic                csFall;
    logic                csRise;
    assign csFall     = csPrev_reg && !hostIn.csLine_b;
    assign csRise     = !csPrev_reg && hostIn.csLine_b;
    assign controlOut = control_reg;
    assign serial_data_line_out  = statusShift_reg[0];
    // Released as soon as chip select rises, not one cycle later.
    assign serial_data_line_oe_b = !((state_reg == PORT_READ) && !hostIn.csLine_b);
    always_comb begin
        state_next       = state_reg;
        shift_next       = shift_reg;
        control_next     = control_reg;
        statusShift_next = statusShift_reg;
        case (state_reg)
            PORT_IDLE: begin
                if (csFall) begin
                    if (hostIn.port_select_line) begin
                        control_next = shift_reg;
                        state_next   = PORT_COMMIT;
                    end else if (hostIn.readNotWrite) begin
                        state_next = PORT_READ;
                    end else begin
                        shift_next = {hostIn.serial_data_line, shift_reg[CTRL_W-1:1]};
                        state_next = PORT_WRITE;
                    end
                end else if (!hostIn.readNotWrite || hostIn.port_select_line) begin
                    // A fresh status snapshot is taken only outside a read sequence,
                    // so bits stay coherent across the strobes of one read.
                    statusShift_next = statusIn;
                end
            end
            PORT_WRITE, PORT_COMMIT: begin
                if (csRise) begin
                    state_next = PORT_IDLE;
                end
            end
            PORT_READ: begin
                if (csRise) begin
                    statusShift_next = {1'b0, statusShift_reg[STATUS_W-1:1]};
                    state_next       = PORT_IDLE;
                end
            end
            default: begin
                state_next = PORT_IDLE;
            end
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg       <= PORT_IDLE;
            shift_reg       <= CTRL_DEFAULT;
            control_reg     <= CTRL_DEFAULT;
            statusShift_reg <= STATUS_ZERO;
            csPrev_reg      <= 1'b1;
        end else begin
            state_reg       <= state_next;
            shift_reg       <= shift_next;
            control_reg     <= control_next;
            statusShift_reg <= statusShift_next;
            csPrev_reg      <= hostIn.csLine_b;
        end
    end
    // ------------------------------------------------------------------
    // Line timing, sync window and field sync
    // ------------------------------------------------------------------
    logic [LINE_CNT_W-1:0] lineCnt_reg;
    logic [LINE_CNT_W-1:0] lineCnt_next;
    logic                  hsPrev_reg;
    logic                  vsPrev_reg;
    logic                  hsFall;
    logic                  vsFall;
    logic                  inWindow;
    logic                  realign;
    logic                  missPoint;
    logic                  seen_reg;
    logic                  seen_next;
    logic                  hit_reg;
    logic                  hit_next;
    logic                  lineSync_reg;
    logic                  lineSync_next;
    logic                  fieldSync_reg;
    logic                  fieldSync_next;
    logic                  fieldDone_reg;
    logic                  fieldDone_next;
    logic                  fieldStart;
    logic [UNLOCK_W-1:0]   unlockCnt_reg;
    logic [UNLOCK_W-1:0]   unlockCnt_next;
    logic                  intLow_reg;
    logic                  intLow_next;
    logic                  outOff_reg;
    assign hsFall     = hsPrev_reg && !hsyncIn_b;
    assign vsFall     = vsPrev_reg && !vsyncIn_b;
    assign inWindow   = (lineCnt_reg <= WIN_CLKS) || (lineCnt_reg >= LINE_PERIOD - WIN_CLKS);
    assign missPoint  = (lineCnt_reg == WIN_CLKS + LINE_ONE);
    // The period is only re-phased when unlocked or across a head switch.
    assign realign    = hsFall && (!hLockIn || headSwitchIn);
    assign fieldStart = vsFall && vblankIn && !fieldDone_reg && hLockIn;
    always_comb begin
        lineCnt_next   = (lineCnt_reg == LINE_PERIOD - LINE_ONE) ? LINE_ZERO
                                                                 : lineCnt_reg + LINE_ONE;
        if (realign) begin
            lineCnt_next = LINE_ZERO;
        end
        lineSync_next  = !(hLockIn && (lineCnt_next < LINE_SYNC_WIDTH)
                           && (lineCnt_next == LINE_ZERO || !lineSync_reg));
        seen_next      = seen_reg;
        hit_next       = hit_reg;
        if (hsFall) begin
            hit_next  = inWindow;
            seen_next = inWindow;
        end else if (missPoint) begin
            if (!seen_reg) begin
                hit_next = 1'b0;
            end
            seen_next = 1'b0;
        end
        fieldSync_next = fieldSync_reg;
        fieldDone_next = fieldDone_reg;
        if (!vblankIn) begin
            fieldSync_next = 1'b1;
            fieldDone_next = 1'b0;
        end else if (fieldStart) begin
            fieldSync_next = 1'b0;
            fieldDone_next = 1'b1;
        end
        unlockCnt_next = unlockCnt_reg;
        if (fieldStart) begin
            unlockCnt_next = UNLOCK_ZERO;
        end else if (lineCnt_reg == LINE_ZERO && !hLockIn && unlockCnt_reg != LOCK_LOSS_LINES) begin
            unlockCnt_next = unlockCnt_reg + UNLOCK_ONE;
        end
        intLow_next = intLow_reg;
        if (hLockIn) begin
            intLow_next = 1'b0;
        end else if (unlockCnt_reg >= LOCK_LOSS_LINES) begin
            intLow_next = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            lineCnt_reg   <= LINE_ZERO;
            hsPrev_reg    <= 1'b1;
            vsPrev_reg    <= 1'b1;
            seen_reg      <= 1'b0;
            hit_reg       <= 1'b0;
            lineSync_reg  <= 1'b1;
            fieldSync_reg <= 1'b1;
            fieldDone_reg <= 1'b0;
            unlockCnt_reg <= UNLOCK_ZERO;
            intLow_reg    <= 1'b0;
            outOff_reg    <= 1'b1;
        end else begin
            lineCnt_reg   <= lineCnt_next;
            hsPrev_reg    <= hsyncIn_b;
            vsPrev_reg    <= vsyncIn_b;
            seen_reg      <= seen_next;
            hit_reg       <= hit_next;
            lineSync_reg  <= lineSync_next;
            fieldSync_reg <= fieldSync_next;
            fieldDone_reg <= fieldDone_next;
            unlockCnt_reg <= unlockCnt_next;
            intLow_reg    <= intLow_next;
            outOff_reg    <= 1'b0;
        end
    end

    assign genlocked_line_sync_out_b  = lineSync_reg;
    assign genlocked_field_sync_out_b = fieldSync_reg;
    assign lockLossInt_b              = !intLow_reg;
    assign syncWindowHit              = hit_reg;
    assign busOe_b                    = outOff_reg;
    // ------------------------------------------------------------------
    // Composite stream
    // ------------------------------------------------------------------
    logic                 phase_reg;
    logic [ANC_IDX_W-1:0] ancIdx_reg;
    logic [ANC_IDX_W-1:0] ancIdx_next;
    logic                 lost_reg;
    logic                 pushValid;
    logic                 pushReady;
    logic [COMP_W-1:0]    pushData;
    logic [COMP_W-1:0]    ancWord;
    assign pushValid = phase_reg && !outOff_reg;
    always_comb begin
        case (ancIdx_reg)
            ANC_FIELD_ID:  ancWord = {7'h00, ancIn.fieldId};
            ANC_FREQ_HIGH: ancWord = ancIn.scFreq[15:8];
            ANC_FREQ_LOW:  ancWord = ancIn.scFreq[7:0];
            ANC_PHASE:     ancWord = ancIn.scPhase;
            default:       ancWord = ANC_FILL;
        endcase
        pushData    = hsyncIn_b ? videoIn : ancWord;
        ancIdx_next = ancIdx_reg;
        if (hsyncIn_b) begin
            ancIdx_next = ANC_FIELD_ID;
        end else if (pushValid && pushReady && ancIdx_reg != ANC_DONE) begin
            // A refused ancillary word is retried, so none is skipped.
            ancIdx_next = ancIdx_reg + 3'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            phase_reg  <= 1'b0;
            ancIdx_reg <= ANC_FIELD_ID;
            lost_reg   <= 1'b0;
        end else begin
            phase_reg  <= !phase_reg;
            ancIdx_reg <= ancIdx_next;
            lost_reg   <= pushValid && !pushReady;
        end
    end
    assign sampleLost = lost_reg;
    two_entry_buffer #(
        .WIDTH (COMP_W),
        .DEPTH (BUF_DEPTH)
    ) compBuffer (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushData),
        .outValid (compValid),
        .outReady (compReady),
        .outData  (composite_output_bus)
    );
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sync_fall_a: assert property ($fell(lineSync_reg)
        |-> lineCnt_reg == LINE_ZERO && $past(hLockIn))
        else $error("line sync fell away from line start");
    line_period_a: assert property (lineCnt_reg == LINE_PERIOD - LINE_ONE && !realign |=> lineCnt_reg == LINE_ZERO)
        else $error("line period not constant");
    field_sync_a: assert property (fieldStart |=> !fieldSync_reg && fieldDone_reg)
        else $error("field sync did not fall");
    comp_rate_a: assert property (pushValid |=> !pushValid ##1 pushValid)
        else $error("sample rate not half clock");
    anc_word_a: assert property (!hsyncIn_b && ancIdx_reg == ANC_FIELD_ID |-> pushData[0] == ancIn.fieldId)
        else $error("field id word wrong");
    shift_in_a: assert property (state_reg == PORT_IDLE && csFall && !hostIn.port_select_line
        && !hostIn.readNotWrite |=> shift_reg[CTRL_W-1] == $past(hostIn.serial_data_line))
        else $error("serial bit not shifted in");
    commit_a: assert property (state_reg == PORT_IDLE && csFall && hostIn.port_select_line
        |=> control_reg == $past(shift_reg))
        else $error("commit did not copy shift register");
    release_a: assert property (hostIn.csLine_b |-> serial_data_line_oe_b)
        else $error("serial line driven with chip select high");
    read_drive_a: assert property (state_reg == PORT_READ && !hostIn.csLine_b
        |-> !serial_data_line_oe_b && serial_data_line_out == statusShift_reg[0])
        else $error("status bit not driven");
    reset_state_a: assert property (disable iff (1'b0) !rst_b |=> state_reg == PORT_IDLE
        && control_reg == CTRL_DEFAULT && busOe_b)
        else $error("reset did not restore defaults");
    int_low_a: assert property (!hLockIn && unlockCnt_reg >= LOCK_LOSS_LINES |=> !lockLossInt_b)
        else $error("interrupt not asserted");
    int_release_a: assert property (hLockIn |=> lockLossInt_b)
        else $error("interrupt not released");
    win_hit_a: assert property (hsFall && inWindow |=> syncWindowHit)
        else $error("window hit not flagged");
    win_miss_a: assert property (missPoint && !seen_reg && !hsFall |=> !syncWindowHit)
        else $error("window miss not flagged");
    commit_c: cover property (state_reg == PORT_COMMIT);
    read_c:   cover property (state_reg == PORT_READ ##1 csRise);
    miss_c:   cover property ($fell(syncWindowHit));
    int_c:    cover property ($fell(lockLossInt_b));
endmodule : genlock_serial_port

// ### hdl/genlock_pkg.sv
package genlock_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CTRL_W      = 47;
    localparam int STATUS_W    = 12;
    localparam int COMP_W      = 8;
    localparam int LINE_CNT_W  = 12;
    localparam int UNLOCK_W    = 8;
    localparam int ANC_IDX_W   = 3;
    localparam int BUF_DEPTH   = 2;

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [CTRL_W-1:0]     CTRL_DEFAULT        = 47'h0000_0000_0000;
    localparam logic [STATUS_W-1:0]   STATUS_ZERO         = 12'h000;
    localparam logic [LINE_CNT_W-1:0] LINE_PERIOD_DEFAULT = 12'h6B4;
    localparam logic [LINE_CNT_W-1:0] LINE_SYNC_WIDTH     = 12'h040;
    localparam logic [LINE_CNT_W-1:0] WIN_PIXELS          = 12'h010;
    localparam logic [LINE_CNT_W-1:0] CLKS_PER_PIXEL      = 12'h002;
    localparam logic [LINE_CNT_W-1:0] WIN_CLKS            = WIN_PIXELS * CLKS_PER_PIXEL;
    localparam logic [LINE_CNT_W-1:0] LINE_ZERO           = 12'h000;
    localparam logic [LINE_CNT_W-1:0] LINE_ONE            = 12'h001;
    localparam logic [UNLOCK_W-1:0]   LOCK_LOSS_LINES     = 8'h80;
    localparam logic [UNLOCK_W-1:0]   UNLOCK_ZERO         = 8'h00;
    localparam logic [UNLOCK_W-1:0]   UNLOCK_ONE          = 8'h01;

    // ------------------------------------------------------------------
    // Ancillary words sent during line sync, in this order
    // ------------------------------------------------------------------
    localparam logic [ANC_IDX_W-1:0] ANC_FIELD_ID   = 3'h0;
    localparam logic [ANC_IDX_W-1:0] ANC_FREQ_HIGH  = 3'h1;
    localparam logic [ANC_IDX_W-1:0] ANC_FREQ_LOW   = 3'h2;
    localparam logic [ANC_IDX_W-1:0] ANC_PHASE      = 3'h3;
    localparam logic [ANC_IDX_W-1:0] ANC_DONE       = 3'h4;
    localparam logic [COMP_W-1:0]    ANC_FILL       = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic csLine_b;
        logic readNotWrite;
        logic port_select_line;
        logic serial_data_line;
    } serial_in_t;

    typedef struct packed {
        logic        fieldId;
        logic [15:0] scFreq;
        logic [7:0]  scPhase;
    } anc_t;

    typedef enum logic [3:0] {
        PORT_IDLE   = 4'h1,
        PORT_WRITE  = 4'h2,
        PORT_READ   = 4'h4,
        PORT_COMMIT = 4'h8
    } port_state_t;

endpackage : genlock_pkg

// ### hdl/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // Filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0]   FULL_CNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
    localparam logic [PTR_W:0]   CNT_ONE  = (PTR_W+1)'(1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] wrPtr_next;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W-1:0] rdPtr_next;
    logic [PTR_W:0]   count_reg;
    logic [PTR_W:0]   count_next;
    logic             push;
    logic             pop;

    assign inReady  = (count_reg != FULL_CNT);
    assign outValid = (count_reg != '0);
    assign outData  = mem_reg[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        mem_next   = mem_reg;
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wrPtr_reg] = inData;
            wrPtr_next = (wrPtr_reg == LAST_PTR) ? PTR_ZERO : wrPtr_reg + PTR_ONE;
        end
        if (pop) begin
            rdPtr_next = (rdPtr_reg == LAST_PTR) ? PTR_ZERO : rdPtr_reg + PTR_ONE;
        end
        if (push && !pop) begin
            count_next = count_reg + CNT_ONE;
        end else if (pop && !push) begin
            count_next = count_reg - CNT_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wrPtr_reg <= PTR_ZERO;
            rdPtr_reg <= PTR_ZERO;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage carries no reset; it is only read while count says it is valid.
    always_ff @(posedge ref_clk) begin
        mem_reg <= mem_next;
    end

endmodule : two_entry_buffer

// ### testbench/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model
    import genlock_pkg::*;
(
    // Clock and device pin side
    input  wire logic  ref_clk,
    input  wire logic  devData,
    input  wire logic  devOe_b,
    // Host pins
    output serial_in_t hostIn
);
    logic csLine_b = 1'b1;
    logic rnw      = 1'b0;
    logic sel      = 1'b0;
    logic drv      = 1'b0;
    // A released pin shows the inverse of the last level, so stale data never reads true.
    assign hostIn = '{csLine_b, rnw, sel, devOe_b ? drv : devData};
    task automatic xfer(input logic r, input logic p, input logic d, output logic q);
        @(negedge ref_clk);
        rnw = r;
        sel = p;
        drv = r ? ~drv : d;
        @(negedge ref_clk);
        csLine_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        q = hostIn.serial_data_line;
        csLine_b = 1'b1;
        drv = ~drv;
        @(negedge ref_clk);
    endtask : xfer
endmodule : serial_host_model

// ### testbench/genlock_serial_port_tb_top.sv
`timescale 1ns/100ps
module genlock_serial_port_tb_top;
    import genlock_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, hsyncIn_b = 1'b1, vsyncIn_b = 1'b1, vblankIn = 1'b0;
    logic hLockIn = 1'b0, headSwitchIn = 1'b0, compReady = 1'b1, hsEn = 1'b0;
    logic [STATUS_W-1:0] statusIn = 12'hA53;
    logic [COMP_W-1:0] videoIn = 8'hEE, composite_output_bus;
    anc_t ancIn = '{1'b1, 16'h1234, 8'h56};
    serial_in_t hostIn;
    logic [CTRL_W-1:0] controlOut;
    logic serial_data_line_out, serial_data_line_oe_b, genlocked_line_sync_out_b, busOe_b;
    logic genlocked_field_sync_out_b, lockLossInt_b, syncWindowHit, compValid, sampleLost;
    int errors = 0, compares = 0, cycles = 0, hsCnt = 0;
    genlock_serial_port #(.LINE_PERIOD(12'h064)) dut_u (
        .ref_clk, .rst_b, .hostIn, .serial_data_line_out, .serial_data_line_oe_b, .controlOut,
        .statusIn, .hsyncIn_b, .vsyncIn_b, .vblankIn, .hLockIn, .headSwitchIn,
        .genlocked_line_sync_out_b, .genlocked_field_sync_out_b, .lockLossInt_b, .syncWindowHit,
        .busOe_b, .videoIn, .ancIn, .composite_output_bus, .compValid, .compReady, .sampleLost);
    serial_host_model host_u (.ref_clk, .devData(serial_data_line_out),
        .devOe_b(serial_data_line_oe_b), .hostIn);
    initial forever #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        hsCnt <= (hsCnt == 99) ? 0 : hsCnt + 1;
        hsyncIn_b <= !(hsEn && hsCnt < 8);
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic fall(output int n);
        logic p;
        n = 0;
        do begin
            p = genlocked_line_sync_out_b;
            @(negedge ref_clk);
            n++;
        end while (!(p && !genlocked_line_sync_out_b) && n < 300);
    endtask : fall
    task automatic test_reset();
        repeat (6) @(negedge ref_clk);
        chk("reset outputs", 5'h1E, {genlocked_line_sync_out_b, lockLossInt_b, busOe_b,
            serial_data_line_oe_b, syncWindowHit});
        rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("resumed", {1'b0, CTRL_DEFAULT}, {busOe_b, controlOut});
        $display("test reset done");
    endtask : test_reset
    task automatic test_serial();
        logic [CTRL_W-1:0]   w = 47'h5A5A_1234_C3C3;
        logic [STATUS_W-1:0] s;
        logic                b;
        for (int i = 0; i < CTRL_W; i++) host_u.xfer(1'b0, 1'b0, w[i], b);
        chk("control held", CTRL_DEFAULT, controlOut);
        host_u.xfer(1'b0, 1'b1, 1'b0, b);
        chk("control", w, controlOut);
        for (int i = 0; i < STATUS_W; i++) host_u.xfer(1'b1, 1'b0, 1'b0, s[i]);
        chk("status", 12'hA53, s);
        chk("data enable", 1'b1, serial_data_line_oe_b);
        $display("test serial port done");
    endtask : test_serial
    task automatic test_timing();
        int n;
        hsEn = 1'b1;
        repeat (150) @(negedge ref_clk);
        hLockIn = 1'b1;
        fall(n);
        fall(n);
        chk("line period", 100, n);
        chk("window hit", 1'b1, syncWindowHit);
        hsEn = 1'b0;
        repeat (200) @(negedge ref_clk);
        chk("window miss", 1'b0, syncWindowHit);
        hLockIn = 1'b0;
        repeat (14000) @(negedge ref_clk);
        chk("interrupt", 1'b0, lockLossInt_b);
        hLockIn = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("interrupt", 1'b1, lockLossInt_b);
        vblankIn = 1'b1;
        vsyncIn_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("field sync", 1'b0, genlocked_field_sync_out_b);
        vblankIn = 1'b0;
        $display("test timing done");
    endtask : test_timing
    task automatic test_composite();
        logic [COMP_W-1:0] q[$];
        logic              b = 1'b0;
        int                n = 0;
        repeat (40) @(negedge ref_clk) if (compValid === 1'b1) n++;
        chk("sample rate", 20, n);
        compReady = 1'b0;
        repeat (8) @(negedge ref_clk) if (sampleLost === 1'b1) b = 1'b1;
        chk("sample lost", 1'b1, b);
        compReady = 1'b1;
        // Start well clear of a sync pulse, so the first ancillary burst is whole.
        while (hsCnt != 50) @(negedge ref_clk);
        hsEn = 1'b1;
        n = 0;
        while (q.size() < 4 && n < 400) begin
            @(negedge ref_clk);
            n++;
            if (compValid === 1'b1 && composite_output_bus !== 8'hEE) q.push_back(composite_output_bus);
        end
        chk("anc words", 32'h0112_3456, {q[0], q[1], q[2], q[3]});
        $display("test composite done");
    endtask : test_composite
    initial begin
        test_reset();
        test_serial();
        test_timing();
        test_composite();
        close_out();
    end
endmodule : genlock_serial_port_tb_top
